// ===== hdl/cif_feature_regs.sv
// camera image feature register bank: shading control, deferred transport, frame tally
// assumes all pipeline inputs are pulses or levels from logic on aclk
// Notes on behaviour
// R1: correction runs only when enabled and a correction image is present
// R2: correction image shown as video only while enable and display both set
// R3: control bits: 4 display, 5 build request, 6 enable, 7 busy
// R4: bit 1 set by hardware when a correction image build fails
// R5: store channel fault code reported in bits 16 to 19
// R6: fault codes 0 none, 1 to 5 store faults, f channel out of range
// R7: bits 20 to 23 select store channel for save and load
// R8: average count in bits 24 to 31, written value rounded to power of two
// R9: host sets count then request; hardware clears busy and request on finish
// R10: requested frames averaged at current settings before factor calculation
// R11: host polls control register sparingly during a build, about 500 ms
// R12: window access register: write enable 5, read enable 6, offset 8 to 31
// R13: host reads limits, sets enable, offset zero, moves chunks, clears enables
// R14: window offset advances by itself after each chunk through the buffer
// R15: host splits correction image transfer into several chunks
// R16: capability register: channel count bits 4 to 7, max bytes 8 to 31
// R17: while hold is set captured images stay queued and are not sent
// R18: release bit sends requested held images then clears itself
// R19: count bits write release count, read held count; capacity in 16 to 23
// R20: max rate capture bit honoured only in the scalable image format
// R21: 32-bit tally counts every sensor readout, sent or not
// R22: frame info bit 1 clears tally; tally readable at a mirror address
// R23: bit 0 of each feature register except the frame count and its mirror reads one, showing presence
// R24: busy is set in the same update that accepts a build request
`timescale 1ns/1ps
module cif_feature_regs
  import cif_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire cif_axi_req_t axi_req,
  output cif_axi_rsp_t axi_rsp,
  input wire logic image_valid_strobe,
  input wire logic correction_image_loaded,
  input wire logic factor_calc_done,
  input wire logic factor_calc_fail,
  input wire logic [3:0] store_fault_code,
  input wire logic chunk_done,
  input wire logic [CIF_CHUNK_W-1:0] chunk_bytes,
  input wire logic image_sent,
  input wire logic scalable_format,
  output logic correction_active,
  output logic display_correction_image,
  output logic build_averaging,
  output logic factor_calc_start,
  output logic [3:0] store_channel_select,
  output logic window_write_enable,
  output logic window_read_enable,
  output logic [CIF_OFFSET_W-1:0] window_byte_offset,
  output logic hold_transfer,
  output logic max_rate_capture,
  output logic transmit_permit
);

  // bus slave state
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_have_ff, w_have_ff;
  logic [31:0] aw_addr_ff, w_data_ff, rdata_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  // feature state
  logic display_ff, enable_ff, build_request_ff, build_failed_ff, present_ff;
  logic [3:0] channel_ff, fault_ff;
  logic [7:0] average_ff, frames_left_ff;
  cif_build_state_t build_state_ff;
  logic calc_start_ff, averaging_ff, active_ff, show_ff;
  logic win_wr_ff, win_rd_ff;
  logic [CIF_OFFSET_W-1:0] offset_ff;
  logic hold_ff, max_rate_ff, max_rate_out_ff, permit_ff;
  logic [7:0] release_left_ff, held_ff;
  logic [31:0] tally_ff;

  logic wr_commit, wr_hit, rd_hit;
  logic [31:0] wr_old, wr_data, rd_value;
  logic busy;
  logic [7:0] average_pow2;
  logic [7:0] nxt_held;

  assign busy = (build_state_ff != CIF_BUILD_IDLE);
  assign wr_commit = aw_have_ff && w_have_ff && !bvalid_ff;

  // register image as software sees it; used for reads and byte-lane merging
  function automatic logic [32:0] cif_read(input logic [31:0] addr);
    logic [31:0] v;
    logic hit;
    v = '0;
    hit = 1'b1;
    unique case (addr)
      CIF_SHADING_CONTROL_ADDR: begin
        v[CIF_PRESENT_BIT] = 1'b1; // R23
        v[CIF_BUILD_FAILED_BIT] = build_failed_ff; // R4
        v[CIF_DISPLAY_BIT] = display_ff; // R3
        v[CIF_BUILD_REQUEST_BIT] = build_request_ff; // R3
        v[CIF_SHADING_ENABLE_BIT] = enable_ff; // R3
        v[CIF_BUSY_BIT] = busy; // R3
        v[CIF_FAULT_LSB +: CIF_FAULT_W] = fault_ff; // R5
        v[CIF_CHANNEL_LSB +: CIF_CHANNEL_W] = channel_ff; // R7
        v[CIF_AVERAGE_LSB +: CIF_AVERAGE_W] = average_ff; // R8
      end
      CIF_SHADING_MEMORY_ACCESS_ADDR: begin
        v[CIF_PRESENT_BIT] = 1'b1; // R23
        v[CIF_WINDOW_WRITE_BIT] = win_wr_ff; // R12
        v[CIF_WINDOW_READ_BIT] = win_rd_ff; // R12
        v[CIF_OFFSET_LSB +: CIF_OFFSET_W] = offset_ff; // R12
      end
      CIF_SHADING_CAPABILITY_ADDR: begin
        v[CIF_PRESENT_BIT] = 1'b1; // R23
        v[CIF_CAPACITY_LSB +: CIF_CHANNEL_W] = CIF_CHANNEL_CAPACITY; // R16
        v[CIF_MAX_BYTES_LSB +: CIF_OFFSET_W] = CIF_IMAGE_MAX_BYTES; // R16
      end
      CIF_DEFERRED_TRANSPORT_ADDR: begin
        v[CIF_PRESENT_BIT] = 1'b1; // R23
        v[CIF_RELEASE_BIT] = (release_left_ff != 8'h00); // R18
        v[CIF_HOLD_BIT] = hold_ff; // R17
        v[CIF_MAX_RATE_BIT] = max_rate_ff; // R20
        v[CIF_QUEUE_CAP_LSB +: CIF_QUEUE_W] = CIF_QUEUE_CAPACITY; // R19
        v[CIF_RELEASE_COUNT_LSB +: CIF_QUEUE_W] = held_ff; // R19
      end
      CIF_FRAME_INFO_ADDR: begin
        v[CIF_PRESENT_BIT] = 1'b1; // R23
      end
      CIF_FRAME_COUNT_ADDR, CIF_FRAME_COUNT_MIRROR_ADDR: begin
        v = tally_ff; // R22
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return {hit, v};
  endfunction : cif_read

  always_comb begin
    {rd_hit, rd_value} = cif_read(axi_req.araddr);
    {wr_hit, wr_old} = cif_read(aw_addr_ff);
    for (int b = 0; b < 4; b++) begin
      wr_data[b*8 +: 8] = w_strb_ff[b] ? w_data_ff[b*8 +: 8] : wr_old[b*8 +: 8];
    end
  end

  // round down to the highest set bit; zero stays zero
  always_comb begin
    average_pow2 = 8'h00;
    for (int i = 0; i < CIF_AVERAGE_W; i++) begin
      if (wr_data[CIF_AVERAGE_LSB + i]) begin
        average_pow2 = 8'h01 << i;
      end
    end
  end

  // write address and data are taken independently, answered once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= CIF_RESP_OKAY;
    end else begin
      if (axi_req.awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        aw_have_ff <= 1'b1;
        aw_addr_ff <= axi_req.awaddr;
      end else if (!aw_have_ff && !bvalid_ff) begin
        awready_ff <= 1'b1;
      end
      if (axi_req.wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        w_have_ff <= 1'b1;
        w_data_ff <= axi_req.wdata;
        w_strb_ff <= axi_req.wstrb;
      end else if (!w_have_ff && !bvalid_ff) begin
        wready_ff <= 1'b1;
      end
      if (wr_commit) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? CIF_RESP_OKAY : CIF_RESP_SLVERR;
      end else if (bvalid_ff && axi_req.bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // reads answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= CIF_RESP_OKAY;
    end else if (axi_req.arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_value;
      rresp_ff <= rd_hit ? CIF_RESP_OKAY : CIF_RESP_SLVERR;
    end else if (rvalid_ff && axi_req.rready) begin
      rvalid_ff <= 1'b0;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  assign axi_rsp = '{awready: awready_ff, wready: wready_ff, bvalid: bvalid_ff,
                     bresp: bresp_ff, arready: arready_ff, rvalid: rvalid_ff,
                     rdata: rdata_ff, rresp: rresp_ff};

  // software-owned shading fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      display_ff <= 1'b0;
      enable_ff <= 1'b0;
      channel_ff <= 4'h0;
      average_ff <= 8'h01;
    end else if (wr_commit && aw_addr_ff == CIF_SHADING_CONTROL_ADDR) begin
      display_ff <= wr_data[CIF_DISPLAY_BIT]; // R3
      enable_ff <= wr_data[CIF_SHADING_ENABLE_BIT]; // R3
      channel_ff <= wr_data[CIF_CHANNEL_LSB +: CIF_CHANNEL_W]; // R7
      average_ff <= average_pow2; // R8
    end
  end

  // out-of-range selection overrides whatever the store reports
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_ff <= CIF_FAULT_NONE;
    end else if (channel_ff >= CIF_CHANNEL_CAPACITY) begin
      fault_ff <= CIF_FAULT_RANGE; // R6
    end else begin
      fault_ff <= store_fault_code; // R5
    end
  end

  // build engine: average frames, then hand over to the factor calculator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      build_state_ff <= CIF_BUILD_IDLE;
      build_request_ff <= 1'b0;
      build_failed_ff <= 1'b0;
      frames_left_ff <= 8'h00;
      calc_start_ff <= 1'b0;
      averaging_ff <= 1'b0;
    end else begin
      calc_start_ff <= 1'b0;
      unique case (build_state_ff)
        CIF_BUILD_IDLE: begin
          if (wr_commit && aw_addr_ff == CIF_SHADING_CONTROL_ADDR
              && wr_data[CIF_BUILD_REQUEST_BIT]) begin
            build_state_ff <= CIF_BUILD_AVERAGE; // R24
            build_request_ff <= 1'b1; // R24
            build_failed_ff <= 1'b0;
            averaging_ff <= 1'b1;
            // a zero count still averages one frame
            frames_left_ff <= (average_pow2 == 8'h00) ? 8'h01 : average_pow2; // R10
          end
        end
        CIF_BUILD_AVERAGE: begin
          if (image_valid_strobe) begin
            frames_left_ff <= frames_left_ff - 8'h01; // R10
            if (frames_left_ff == 8'h01) begin
              build_state_ff <= CIF_BUILD_CALC;
              averaging_ff <= 1'b0;
              calc_start_ff <= 1'b1; // R10
            end
          end
        end
        CIF_BUILD_CALC: begin
          if (factor_calc_done) begin
            build_state_ff <= CIF_BUILD_IDLE; // R9
            build_request_ff <= 1'b0; // R9
            build_failed_ff <= factor_calc_fail; // R4
          end
        end
      endcase
    end
  end

  // presence of a usable correction image
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      present_ff <= 1'b0;
    end else if (correction_image_loaded
                 || (build_state_ff == CIF_BUILD_CALC && factor_calc_done && !factor_calc_fail)) begin
      present_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_ff <= 1'b0;
      show_ff <= 1'b0;
    end else begin
      active_ff <= enable_ff && present_ff; // R1
      show_ff <= enable_ff && display_ff; // R2
    end
  end

  // window access; a software offset write wins over a chunk advance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_wr_ff <= 1'b0;
      win_rd_ff <= 1'b0;
      offset_ff <= '0;
    end else if (wr_commit && aw_addr_ff == CIF_SHADING_MEMORY_ACCESS_ADDR) begin
      win_wr_ff <= wr_data[CIF_WINDOW_WRITE_BIT]; // R12
      win_rd_ff <= wr_data[CIF_WINDOW_READ_BIT]; // R12
      offset_ff <= wr_data[CIF_OFFSET_LSB +: CIF_OFFSET_W]; // R12
    end else if (chunk_done && (win_wr_ff || win_rd_ff)) begin
      offset_ff <= offset_ff + CIF_OFFSET_W'(chunk_bytes); // R14
    end
  end

  // deferred transport controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_ff <= 1'b0;
      max_rate_ff <= 1'b0;
    end else if (wr_commit && aw_addr_ff == CIF_DEFERRED_TRANSPORT_ADDR) begin
      hold_ff <= wr_data[CIF_HOLD_BIT]; // R17
      max_rate_ff <= wr_data[CIF_MAX_RATE_BIT]; // R20
    end
  end

  // queue occupancy: frames enter only while held, leave when sent
  always_comb begin
    nxt_held = held_ff;
    if (hold_ff && image_valid_strobe && held_ff < CIF_QUEUE_CAPACITY) begin
      nxt_held = nxt_held + 8'h01; // R17
    end
    if (image_sent && held_ff != 8'h00) begin
      nxt_held = nxt_held - 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_ff <= 8'h00;
    end else begin
      held_ff <= nxt_held;
    end
  end

  // release budget: never more than is held at the moment of the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      release_left_ff <= 8'h00;
    end else if (wr_commit && aw_addr_ff == CIF_DEFERRED_TRANSPORT_ADDR
                 && wr_data[CIF_RELEASE_BIT]) begin
      release_left_ff <= (wr_data[CIF_RELEASE_COUNT_LSB +: CIF_QUEUE_W] < held_ff)
                         ? wr_data[CIF_RELEASE_COUNT_LSB +: CIF_QUEUE_W] : held_ff; // R18
    end else if (image_sent && release_left_ff != 8'h00) begin
      release_left_ff <= release_left_ff - 8'h01; // R18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      permit_ff <= 1'b1;
      max_rate_out_ff <= 1'b0;
    end else begin
      permit_ff <= !hold_ff || (release_left_ff != 8'h00); // R17
      max_rate_out_ff <= max_rate_ff && scalable_format; // R20
    end
  end

  // clear and a same-cycle readout give a tally of one, so no frame is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tally_ff <= '0;
    end else if (wr_commit && aw_addr_ff == CIF_FRAME_INFO_ADDR
                 && wr_data[CIF_CLEAR_TALLY_BIT]) begin
      tally_ff <= {31'h0, image_valid_strobe}; // R22
    end else if (image_valid_strobe) begin
      tally_ff <= tally_ff + 32'h1; // R21
    end
  end

  assign correction_active = active_ff;
  assign display_correction_image = show_ff;
  assign build_averaging = averaging_ff;
  assign factor_calc_start = calc_start_ff;
  assign store_channel_select = channel_ff;
  assign window_write_enable = win_wr_ff;
  assign window_read_enable = win_rd_ff;
  assign window_byte_offset = offset_ff;
  assign hold_transfer = hold_ff;
  assign max_rate_capture = max_rate_out_ff;
  assign transmit_permit = permit_ff;

endmodule : cif_feature_regs

// ===== hdl/cif_pkg.sv
// register map, field layout and bus carriers of the camera image feature bank
// assumes a 32-bit axi4-lite master and one 50 MHz clock
package cif_pkg;

  localparam int unsigned CIF_DATA_W = 32;
  localparam int unsigned CIF_ADDR_W = 32;

  // byte addresses
  localparam logic [31:0] CIF_SHADING_CONTROL_ADDR = 32'hf1000250;
  localparam logic [31:0] CIF_SHADING_MEMORY_ACCESS_ADDR = 32'hf1000254;
  localparam logic [31:0] CIF_SHADING_CAPABILITY_ADDR = 32'hf1000258;
  localparam logic [31:0] CIF_DEFERRED_TRANSPORT_ADDR = 32'hf1000260;
  localparam logic [31:0] CIF_FRAME_INFO_ADDR = 32'hf1000270;
  localparam logic [31:0] CIF_FRAME_COUNT_ADDR = 32'hf1000274;
  localparam logic [31:0] CIF_FRAME_COUNT_MIRROR_ADDR = 32'hf1000610;

  // single-bit fields
  localparam int unsigned CIF_PRESENT_BIT = 0;
  localparam int unsigned CIF_BUILD_FAILED_BIT = 1;
  localparam int unsigned CIF_DISPLAY_BIT = 4;
  localparam int unsigned CIF_BUILD_REQUEST_BIT = 5;
  localparam int unsigned CIF_SHADING_ENABLE_BIT = 6;
  localparam int unsigned CIF_BUSY_BIT = 7;
  localparam int unsigned CIF_WINDOW_WRITE_BIT = 5;
  localparam int unsigned CIF_WINDOW_READ_BIT = 6;
  localparam int unsigned CIF_RELEASE_BIT = 5;
  localparam int unsigned CIF_HOLD_BIT = 6;
  localparam int unsigned CIF_MAX_RATE_BIT = 7;
  localparam int unsigned CIF_CLEAR_TALLY_BIT = 1;

  // multi-bit fields
  localparam int unsigned CIF_FAULT_LSB = 16;
  localparam int unsigned CIF_FAULT_W = 4;
  localparam int unsigned CIF_CHANNEL_LSB = 20;
  localparam int unsigned CIF_CHANNEL_W = 4;
  localparam int unsigned CIF_AVERAGE_LSB = 24;
  localparam int unsigned CIF_AVERAGE_W = 8;
  localparam int unsigned CIF_OFFSET_LSB = 8;
  localparam int unsigned CIF_OFFSET_W = 24;
  localparam int unsigned CIF_CAPACITY_LSB = 4;
  localparam int unsigned CIF_MAX_BYTES_LSB = 8;
  localparam int unsigned CIF_QUEUE_CAP_LSB = 16;
  localparam int unsigned CIF_QUEUE_W = 8;
  localparam int unsigned CIF_RELEASE_COUNT_LSB = 24;
  localparam int unsigned CIF_CHUNK_W = 16;

  // store channel fault codes
  localparam logic [3:0] CIF_FAULT_NONE = 4'h0;
  localparam logic [3:0] CIF_FAULT_DETECT = 4'h1;
  localparam logic [3:0] CIF_FAULT_SIZE = 4'h2;
  localparam logic [3:0] CIF_FAULT_ERASE = 4'h3;
  localparam logic [3:0] CIF_FAULT_WRITE = 4'h4;
  localparam logic [3:0] CIF_FAULT_HEADER = 4'h5;
  localparam logic [3:0] CIF_FAULT_RANGE = 4'hf;

  // capabilities; plain defaults
  localparam logic [3:0] CIF_CHANNEL_CAPACITY = 4'h4;
  localparam logic [23:0] CIF_IMAGE_MAX_BYTES = 24'h100000;
  localparam logic [7:0] CIF_QUEUE_CAPACITY = 8'h20;

  localparam logic [1:0] CIF_RESP_OKAY = 2'h0;
  localparam logic [1:0] CIF_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [CIF_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [CIF_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [CIF_ADDR_W-1:0] araddr;
    logic rready;
  } cif_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [CIF_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } cif_axi_rsp_t;

  typedef enum logic [1:0] {
    CIF_BUILD_IDLE,
    CIF_BUILD_AVERAGE,
    CIF_BUILD_CALC
  } cif_build_state_t;

endpackage : cif_pkg

// ===== tb/cif_feature_asserts.sv
// port-level checks of the camera image feature register bank
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module cif_feature_asserts
  import cif_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire cif_axi_req_t axi_req,
  input wire cif_axi_rsp_t axi_rsp,
  input wire logic chunk_done,
  input wire logic [CIF_CHUNK_W-1:0] chunk_bytes,
  input wire logic scalable_format,
  input wire logic build_averaging,
  input wire logic factor_calc_start,
  input wire logic window_write_enable,
  input wire logic window_read_enable,
  input wire logic [CIF_OFFSET_W-1:0] window_byte_offset,
  input wire logic hold_transfer,
  input wire logic max_rate_capture,
  input wire logic transmit_permit
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic aw_hs;
  logic w_hs;
  assign aw_hs = axi_req.awvalid & axi_rsp.awready;
  assign w_hs = axi_req.wvalid & axi_rsp.wready;

  a_bvalid_hold: assert property (axi_rsp.bvalid |=> axi_rsp.bvalid != $past(axi_req.bready)
    && $stable(axi_rsp.bresp)) else $error("write answer not held");
  a_rvalid_hold: assert property (axi_rsp.rvalid |=> axi_rsp.rvalid != $past(axi_req.rready)
    && $stable(axi_rsp.rdata)) else $error("read answer not held");
  a_write_answer: assert property (aw_hs && w_hs |-> ##2 axi_rsp.bvalid)
    else $error("no write answer");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("no read answer");
  a_aw_ready_drop: assert property (aw_hs |=> !axi_rsp.awready [*2])
    else $error("second write taken too early");
  a_max_rate_fmt: assert property (max_rate_capture |-> $past(scalable_format))
    else $error("max rate outside scalable format");
  a_permit_held: assert property (!transmit_permit |-> hold_transfer || $past(hold_transfer))
    else $error("transmit blocked without hold");
  a_start_pulse: assert property (factor_calc_start |-> $past(build_averaging) ##1
    !factor_calc_start) else $error("calc start not after averaging");
  a_offset_step: assert property (chunk_done && (window_write_enable || window_read_enable)
    && !$past(aw_hs) && !$past(w_hs)
    |=> window_byte_offset == $past(window_byte_offset) + $past(chunk_bytes))
    else $error("window offset not advanced");

  c_build: cover property (factor_calc_start);
  c_chunk: cover property (chunk_done && window_read_enable);
  c_hold: cover property (hold_transfer && !transmit_permit);
endmodule : cif_feature_asserts

// ===== tb/cif_host_model.sv
// axi4-lite host model for the feature register bank
// assumes it is the only master; every wait is bounded
`timescale 1ns/1ps
module cif_host_model
  import cif_pkg::*;
(
  input wire logic aclk,
  output cif_axi_req_t axi_req,
  input wire cif_axi_rsp_t axi_rsp
);
  int hang = 0;
  initial axi_req = '0;

  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (!(axi_req.awvalid && axi_rsp.awready) && axi_req.awvalid && n < 200
      || !(axi_req.wvalid && axi_rsp.wready) && axi_req.wvalid && n < 200);
    do begin
      @(posedge aclk);
      n++;
    end while (!axi_rsp.bvalid && n < 400);
    r = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
    if (n >= 400) hang++;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!axi_rsp.arready && n < 200);
    axi_req.arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!axi_rsp.rvalid && n < 400);
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
    if (n >= 400) hang++;
  endtask : rd
endmodule : cif_host_model

// ===== tb/tb_top.sv
// self-checking bench for the camera image feature register bank
// assumes a 50 MHz clock and the host model as the only bus master
`timescale 1ns/1ps
module tb_top;
  import cif_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  cif_axi_req_t axi_req;
  cif_axi_rsp_t axi_rsp;
  logic image_valid_strobe = 1'b0, correction_image_loaded = 1'b0, image_sent = 1'b0;
  logic factor_calc_done = 1'b0, factor_calc_fail = 1'b0, chunk_done = 1'b0;
  logic scalable_format = 1'b0;
  logic [3:0] store_fault_code = 4'h0;
  logic [15:0] chunk_bytes = 16'h0;
  logic correction_active, display_correction_image, build_averaging, factor_calc_start;
  logic window_write_enable, window_read_enable, hold_transfer, max_rate_capture;
  logic transmit_permit;
  logic [3:0] store_channel_select;
  logic [23:0] window_byte_offset;
  int error_cnt = 0;
  int samples_checked = 0;
  int starts = 0;
  logic [31:0] rv;
  logic [1:0] rr;

  always #10 aclk = ~aclk;
  always @(posedge aclk) if (factor_calc_start === 1'b1) starts <= starts + 1;

  cif_host_model i_host (.aclk(aclk), .axi_req(axi_req), .axi_rsp(axi_rsp));
  cif_feature_regs i_dut (.*);

  function automatic logic [7:0] pow2(input logic [7:0] v);
    pow2 = 8'h0;
    for (int i = 0; i < 8; i++) if (v[i]) pow2 = 8'h1 << i;
  endfunction : pow2

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    i_host.rd(a, rv, rr);
    chk(rv, e);
  endtask : rdc

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_host.wr(a, d, rr);
  endtask : wr

  task automatic pulse_img(input int n);
    repeat (n) begin
      @(posedge aclk);
      image_valid_strobe <= 1'b1;
      @(posedge aclk);
      image_valid_strobe <= 1'b0;
    end
  endtask : pulse_img

  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask : settle

  task give_verdict;
    error_cnt += i_host.hang;
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (100000) @(posedge aclk);
    error_cnt++;
    give_verdict;
  end

  initial begin
    logic [7:0] v;
    logic [3:0] ch;
    logic [23:0] off;
    int n;
    void'($urandom(14216));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(CIF_SHADING_CONTROL_ADDR, 32'h01000001);
    rdc(CIF_SHADING_MEMORY_ACCESS_ADDR, 32'h1);
    for (int k = 0; k < 2; k++) begin
      rdc(CIF_SHADING_CAPABILITY_ADDR, {CIF_IMAGE_MAX_BYTES, CIF_CHANNEL_CAPACITY, 4'h1});
      wr(CIF_SHADING_CAPABILITY_ADDR, 32'h0);
    end
    rdc(CIF_DEFERRED_TRANSPORT_ADDR, {8'h0, CIF_QUEUE_CAPACITY, 16'h1});
    rdc(CIF_FRAME_INFO_ADDR, 32'h1);
    rdc(CIF_FRAME_COUNT_ADDR, 32'h0);
    i_host.wr(32'hf1000300, 32'hffffffff, rr);
    chk(32'(rr), 32'(CIF_RESP_SLVERR));
    i_host.rd(32'hf1000300, rv, rr);
    chk({rv[29:0], rr}, {30'h0, CIF_RESP_SLVERR});
    for (int i = 0; i < 7; i++) begin
      v = (i == 0) ? 8'h0 : (i == 1) ? 8'hff : 8'($urandom_range(2, 254));
      ch = (i == 6) ? 4'($urandom_range(4, 15)) : 4'($urandom_range(0, 3));
      store_fault_code <= 4'(i);
      wr(CIF_SHADING_CONTROL_ADDR, {v, ch, 20'h0});
      rdc(CIF_SHADING_CONTROL_ADDR, {pow2(v), ch, (i == 6) ? CIF_FAULT_RANGE : 4'(i), 16'h1});
      chk(32'(store_channel_select), 32'(ch));
    end
    store_fault_code <= 4'h0;
    wr(CIF_SHADING_CONTROL_ADDR, 32'h01000050);
    settle;
    chk(32'({correction_active, display_correction_image}), 32'h1);
    @(posedge aclk);
    correction_image_loaded <= 1'b1;
    @(posedge aclk);
    correction_image_loaded <= 1'b0;
    settle;
    chk(32'({correction_active, display_correction_image}), 32'h3);
    wr(CIF_SHADING_CONTROL_ADDR, 32'h01000010);
    settle;
    chk(32'({correction_active, display_correction_image}), 32'h0);
    for (int f = 1; f >= 0; f--) begin
      v = (f == 1) ? 8'h2 : 8'h1;
      wr(CIF_SHADING_CONTROL_ADDR, {v, 24'h0});
      wr(CIF_SHADING_CONTROL_ADDR, {v, 24'h20});
      rdc(CIF_SHADING_CONTROL_ADDR, {v, 24'ha1});
      chk(32'(build_averaging), 32'h1);
      pulse_img(v);
      settle;
      chk(32'(build_averaging), 32'h0);
      @(posedge aclk);
      factor_calc_done <= 1'b1;
      factor_calc_fail <= 1'(f);
      @(posedge aclk);
      factor_calc_done <= 1'b0;
      factor_calc_fail <= 1'b0;
      settle;
      rdc(CIF_SHADING_CONTROL_ADDR, {v, 22'h0, 1'(f), 1'b1});
    end
    chk(32'(starts), 32'h2);
    for (int k = 5; k < 7; k++) begin
      off = 24'h0;
      wr(CIF_SHADING_MEMORY_ACCESS_ADDR, 32'h1 << k);
      for (int j = 0; j < 3; j++) begin
        n = $urandom_range(1, 4096);
        @(posedge aclk);
        chunk_bytes <= 16'(n);
        chunk_done <= 1'b1;
        @(posedge aclk);
        chunk_done <= 1'b0;
        off += 24'(n);
      end
      settle;
      chk(32'(window_byte_offset), 32'(off));
      rdc(CIF_SHADING_MEMORY_ACCESS_ADDR, {off, 8'h1} | (32'h1 << k));
      chk(32'({window_read_enable, window_write_enable}), 32'(k - 4));
    end
    wr(CIF_SHADING_MEMORY_ACCESS_ADDR, 32'h0);
    settle;
    chk(32'({window_read_enable, window_write_enable}), 32'h0);
    wr(CIF_DEFERRED_TRANSPORT_ADDR, 32'h40);
    settle;
    chk(32'({hold_transfer, transmit_permit}), 32'h2);
    pulse_img(3);
    rdc(CIF_DEFERRED_TRANSPORT_ADDR, {8'h3, CIF_QUEUE_CAPACITY, 16'h41});
    wr(CIF_DEFERRED_TRANSPORT_ADDR, 32'h02000060);
    settle;
    chk(32'(transmit_permit), 32'h1);
    rdc(CIF_DEFERRED_TRANSPORT_ADDR, {8'h3, CIF_QUEUE_CAPACITY, 16'h61});
    repeat (2) begin
      @(posedge aclk);
      image_sent <= 1'b1;
      @(posedge aclk);
      image_sent <= 1'b0;
    end
    settle;
    rdc(CIF_DEFERRED_TRANSPORT_ADDR, {8'h1, CIF_QUEUE_CAPACITY, 16'h41});
    chk(32'(transmit_permit), 32'h0);
    for (int s = 0; s < 2; s++) begin
      scalable_format <= 1'(s);
      wr(CIF_DEFERRED_TRANSPORT_ADDR, 32'h80);
      settle;
      chk(32'(max_rate_capture), 32'(s));
    end
    wr(CIF_FRAME_INFO_ADDR, 32'h2);
    n = $urandom_range(3, 9);
    pulse_img(n);
    settle;
    rdc(CIF_FRAME_COUNT_ADDR, 32'(n));
    rdc(CIF_FRAME_COUNT_MIRROR_ADDR, 32'(n));
    rdc(CIF_FRAME_INFO_ADDR, 32'h1);
    give_verdict;
  end
endmodule : tb_top

bind cif_feature_regs cif_feature_asserts i_chk (.*);
